// *** src/pcc_pkg.sv ***
// pcc_pkg: constants and types of the clock-conditioning configuration block
// assumes one 125 MHz register clock and AXI4-Lite register access
package pcc_pkg;
   // timing
   localparam int CLK_PS       = 8000;
   localparam int DLY_STEP_PS  = 250;
   localparam int DLY_CEIL     = (DLY_STEP_PS + CLK_PS - 1) / CLK_PS;
   localparam int DLY_STEP_CYC = (DLY_CEIL < 1) ? 1 : DLY_CEIL;
   // register byte addresses
   localparam logic [7:0] ADDR_CFG  = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_DYN  = 8'h0C;
   // configuration word, shared by the static register and the serial frame
   localparam int CFG_W  = 31;
   localparam int IN_LSB = 0;
   localparam int IN_W   = 5;
   localparam int FB_LSB = 5;
   localparam int FB_W   = 6;
   localparam int PD_LSB = 11;
   localparam int SD_LSB = 13;
   localparam int DIV_W  = 2;
   localparam int PR_LSB = 15;
   localparam int PR_W   = 3;
   localparam int SR_LSB = 18;
   localparam int SR_W   = 2;
   localparam int FS_LSB = 20;
   localparam int FS_W   = 2;
   localparam int FD_LSB = 22;
   localparam int FD_W   = 4;
   localparam int PDL_LSB = 26;
   localparam int SDL_LSB = 28;
   localparam int DLS_W  = 2;
   localparam int XD_BIT = 30;
   // control and status bits
   localparam int CTRL_MODE = 0;
   localparam int CTRL_PSEL = 1;
   localparam int CTRL_SSEL = 2;
   localparam int ST_LOCK   = 0;
   localparam int ST_CORE   = 1;
   localparam int ST_SOUT   = 2;
   localparam int ST_DYN    = 3;
   // reset values and masks
   localparam logic [31:0] CFG_RST   = 32'h0000_0000;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] CFG_MASK  = 32'h7FFF_FFFF;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // route and feedback codes
   localparam logic [2:0] PR_BYP  = 3'h0;
   localparam logic [2:0] PR_GMUX = 3'h1;
   localparam logic [2:0] PR_DLY  = 3'h2;
   localparam logic [2:0] PR_RSV  = 3'h3;
   localparam logic [1:0] SR_BYP  = 2'h0;
   localparam logic [1:0] SR_GMUX = 2'h1;
   localparam logic [1:0] SR_DLY  = 2'h2;
   localparam logic [1:0] SR_PH0  = 2'h3;
   localparam logic [1:0] FS_GND  = 2'h0;
   localparam logic [1:0] FS_DLY  = 2'h1;
   localparam logic [1:0] FS_VCO  = 2'h2;
   localparam logic [1:0] FS_EXT  = 2'h3;
   typedef enum logic [2:0] {
      lk_off    = 3'h1,
      lk_acq    = 3'h2,
      lk_locked = 3'h4
   } pcc_lock_t;
endpackage

// *** src/pcc_top.sv ***
// pcc_top: clock-conditioning configuration, cycle model of the loop and output paths
// assumes reference and feedback clocks synchronous to aclk, AXI4-Lite master
//
// Contract
// [R1] input divider divides by code plus one
// [R2] feedback divider multiplies by code plus one
// [R3] primary output divider: 00 is one, up to four
// [R4] secondary output divider divides by one to four
// [R5] secondary delay 00 adds no delay
// [R6] primary delay 00 adds no delay
// [R7] feedback delay in 250ps steps from one step
// [R8] primary route: bypass, global mux, delay line, reserved
// [R9] primary route 100..111 picks oscillator phases
// [R10] secondary route: bypass, global mux, delay, phase 0
// [R11] feedback 00 grounded, 01 delay line
// [R12] feedback 10 oscillator phase 0, 11 external
// [R13] lock low while not locked
// [R14] mode 0 static, otherwise dynamic
// [R15] serial output shows shift register end
// [R16] secondary reference used only when bypassed; code uses secondary_ref_in only on secondary route 01, global mux
// [R17] surroundings wire external feedback pad in
// [R18] static mux bits pick both reference sources
// [R19] serial inputs and extra delay only dynamic
// [R20] two clock outputs, primary and secondary
// [R21] outputs are oscillator divided by output divider
// [R22] both bypassed: core and input divider off
// [R23] static settings held constant while running
`timescale 1ns/100ps
module pcc_out_path #(
   parameter int DL_LEN = 32
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // source and settings
   input  wire logic       src,
   input  wire logic [1:0] div_sel,
   input  wire logic [1:0] dly_sel,
   // conditioned clock
   output logic            clk_out
);
   logic              src_q;
   logic [1:0]        cnt;
   logic              divo;
   logic [DL_LEN-1:0] dl;
   logic [1:0]        half;
   logic [4:0]        taps;

   assign half = 2'(({1'b0, div_sel} + 3'h2) >> 1);
   assign taps = 5'({3'h0, dly_sel} * pcc_pkg::DLY_STEP_CYC);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         src_q <= 1'b0;
         cnt <= 2'h0;
      end else begin
         src_q <= src;
         if (src && !src_q) begin
            cnt <= (cnt == div_sel) ? 2'h0 : cnt + 2'h1; // [R3] [R4]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         divo <= 1'b0;
         dl <= '0;
         clk_out <= 1'b0;
      end else begin
         divo <= (div_sel == 2'h0) ? src : (cnt < half); // [R21]
         dl <= {dl[DL_LEN-2:0], divo};
         clk_out <= (taps == 5'h00) ? divo : dl[taps - 5'h01]; // [R5] [R6]
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence plain_s;
      (div_sel == 2'h0 && dly_sel == 2'h0) [*3];
   endsequence

   direct_path_a: // [R3] [R5] [R6]
      assert property (plain_s |-> clk_out == $past(src, 2))
      else $error("undivided undelayed path does not follow its source");
   divide_wrap_a: // [R4]
      assert property (src && !src_q && cnt == div_sel |=> cnt == 2'h0)
      else $error("output divider does not wrap at its code");
endmodule

module pcc_top #(
   parameter int PER_W        = 16,
   parameter int LOCK_PERIODS = 4,
   parameter int DL_LEN       = 32
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // AXI4-Lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // reference and feedback clocks
   input  wire logic        primary_ref_pad,
   input  wire logic        primary_ref_int,
   input  wire logic        secondary_ref_pad,
   input  wire logic        secondary_ref_int,
   input  wire logic        ext_feedback_in,
   // serial configuration
   input  wire logic        cfg_serial_clk,
   input  wire logic        cfg_shift_en,
   input  wire logic        cfg_serial_in,
   input  wire logic        cfg_update_strobe,
   output logic             cfg_serial_out,
   // conditioned clocks and lock
   output logic             primary_clk_out,
   output logic             secondary_clk_out,
   output logic             lock
);
   localparam int W = pcc_pkg::CFG_W;

   logic [31:0]        cfg_reg;
   logic [31:0]        ctrl_reg;
   logic [W-1:0]       shreg;
   logic [W-1:0]       dyn_cfg;
   logic [W-1:0]       eff;
   logic               mode;
   logic [4:0]         n_sel;
   logic [5:0]         m_sel;
   logic [2:0]         pr;
   logic [1:0]         sr;
   logic [1:0]         fs;
   logic [3:0]         fd;
   logic               prim_ref;
   logic               secondary_ref_in;
   logic               core_on;
   logic               pref_q;
   logic               ext_q;
   logic               sclk_q;
   logic               upd_q;
   logic               vdlo_q;
   logic [4:0]         in_cnt;
   logic               ref_tick;
   logic [PER_W-1:0]   per_cnt;
   logic [PER_W-1:0]   period;
   logic [PER_W-1:0]   acc;
   logic [PER_W:0]     acc_sum;
   logic               tick;
   logic [1:0]         vco_ph;
   logic [DL_LEN-1:0]  vdl;
   logic               vdl_out;
   logic               fb_ev;
   logic               fb_wrap;
   logic [5:0]         fb_cnt;
   logic [1:0]         hits;
   logic               good;
   logic [7:0]         good_cnt;
   pcc_pkg::pcc_lock_t state;
   pcc_pkg::pcc_lock_t next_state;
   logic               psrc;
   logic               ssrc;
   logic               aw_hold;
   logic               w_hold;
   logic [7:0]         aw_q;
   logic [31:0]        wd_q;
   logic [3:0]         ws_q;
   logic               wr_go;
   logic               wr_hit;
   logic [31:0]        rd_word;
   logic               rd_hit;

   function automatic logic phase_lvl(input logic [1:0] ph, input logic [1:0] k);
      logic [1:0] d;
      d = ph - k;
      phase_lvl = ~d[1];
   endfunction

   function automatic logic [4:0] fb_taps(input logic [3:0] code, input logic xd);
      fb_taps = 5'(({1'b0, code} + 5'h01 + {4'h0, xd}) * pcc_pkg::DLY_STEP_CYC);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            merge[8*i +: 8] = d[8*i +: 8];
         end
      end
   endfunction

   // effective configuration
   assign mode = ctrl_reg[pcc_pkg::CTRL_MODE];
   always_comb begin
      eff = mode ? dyn_cfg : cfg_reg[W-1:0]; // [R14]
      if (!mode) begin
         eff[pcc_pkg::XD_BIT] = 1'b0; // [R19]
      end
   end
   assign n_sel = eff[pcc_pkg::IN_LSB +: pcc_pkg::IN_W];
   assign m_sel = eff[pcc_pkg::FB_LSB +: pcc_pkg::FB_W];
   assign pr = eff[pcc_pkg::PR_LSB +: pcc_pkg::PR_W];
   assign sr = eff[pcc_pkg::SR_LSB +: pcc_pkg::SR_W];
   assign fs = eff[pcc_pkg::FS_LSB +: pcc_pkg::FS_W];
   assign fd = eff[pcc_pkg::FD_LSB +: pcc_pkg::FD_W];
   assign prim_ref = ctrl_reg[pcc_pkg::CTRL_PSEL] ? primary_ref_int : primary_ref_pad; // [R18]
   assign secondary_ref_in = ctrl_reg[pcc_pkg::CTRL_SSEL] ? secondary_ref_int
                                                          : secondary_ref_pad; // [R18]
   assign core_on = !(pr[2:1] == 2'h0 && !sr[1]); // [R22]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pref_q <= 1'b0;
         ext_q <= 1'b0;
         sclk_q <= 1'b0;
         upd_q <= 1'b0;
         vdlo_q <= 1'b0;
      end else begin
         pref_q <= prim_ref;
         ext_q <= ext_feedback_in;
         sclk_q <= cfg_serial_clk;
         upd_q <= cfg_update_strobe;
         vdlo_q <= vdl_out;
      end
   end

   // serial configuration path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shreg <= '0;
      end else if (mode && cfg_shift_en && cfg_serial_clk && !sclk_q) begin
         shreg <= {shreg[W-2:0], cfg_serial_in}; // [R19]
      end
   end
   assign cfg_serial_out = shreg[W-1]; // [R15]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dyn_cfg <= '0;
      end else if (mode && cfg_update_strobe && !upd_q) begin
         dyn_cfg <= shreg; // [R19]
      end
   end

   // input divider and reference period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_cnt <= 5'h00;
         ref_tick <= 1'b0;
      end else begin
         ref_tick <= 1'b0;
         if (!core_on) begin
            in_cnt <= 5'h00;
         end else if (prim_ref && !pref_q) begin
            if (in_cnt == n_sel) begin
               in_cnt <= 5'h00; // [R1]
               ref_tick <= 1'b1;
            end else begin
               in_cnt <= in_cnt + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !core_on) begin
         per_cnt <= '0;
         period <= '0;
      end else if (ref_tick) begin
         period <= per_cnt;
         per_cnt <= PER_W'(1);
      end else if (per_cnt != '1) begin
         per_cnt <= per_cnt + PER_W'(1);
      end
   end

   // oscillator: 4*(m+1) quarter-phase ticks per divided reference period
   assign acc_sum = {1'b0, acc} + (PER_W + 1)'({m_sel + 6'h00, 2'h0} + 9'h004);
   assign tick = core_on && period != '0 && acc_sum >= {1'b0, period};

   always_ff @(posedge aclk) begin
      if (!aresetn || !core_on || ref_tick) begin
         acc <= '0; // [R22]
         vco_ph <= 2'h0;
      end else if (tick) begin
         acc <= PER_W'(acc_sum - {1'b0, period}); // [R2]
         vco_ph <= vco_ph + 2'h1;
      end else if (period != '0) begin
         acc <= PER_W'(acc_sum);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vdl <= '0;
      end else begin
         vdl <= {vdl[DL_LEN-2:0], phase_lvl(vco_ph, 2'h0)};
      end
   end
   assign vdl_out = vdl[fb_taps(fd, eff[pcc_pkg::XD_BIT]) - 5'h01]; // [R7]

   // feedback source and feedback divider
   always_comb begin
      unique case (fs)
         pcc_pkg::FS_GND: fb_ev = 1'b0; // [R11]
         pcc_pkg::FS_DLY: fb_ev = vdl_out && !vdlo_q; // [R11]
         pcc_pkg::FS_VCO: fb_ev = tick && vco_ph == 2'h3; // [R12]
         pcc_pkg::FS_EXT: fb_ev = ext_feedback_in && !ext_q; // [R12] [R17]
      endcase
   end
   assign fb_wrap = fb_ev && fb_cnt == m_sel;
   assign good = (hits == 2'h1 && !fb_wrap) || (hits == 2'h0 && fb_wrap);

   always_ff @(posedge aclk) begin
      if (!aresetn || !core_on) begin
         fb_cnt <= 6'h00;
         hits <= 2'h0;
      end else begin
         if (fb_ev) begin
            fb_cnt <= fb_wrap ? 6'h00 : fb_cnt + 6'h01; // [R2]
         end
         if (ref_tick) begin
            hits <= 2'h0; // a wrap on the tick belongs to the closing period
         end else if (fb_wrap && hits != 2'h3) begin
            hits <= hits + 2'h1;
         end
      end
   end

   // lock detection
   always_comb begin
      next_state = state;
      unique case (state)
         pcc_pkg::lk_off: begin
            if (core_on) next_state = pcc_pkg::lk_acq;
         end
         pcc_pkg::lk_acq: begin
            if (ref_tick && good && good_cnt == 8'(LOCK_PERIODS - 1)) begin
               next_state = pcc_pkg::lk_locked;
            end
         end
         pcc_pkg::lk_locked: begin
            if (ref_tick && !good) next_state = pcc_pkg::lk_acq;
         end
      endcase
      if (!core_on) begin
         next_state = pcc_pkg::lk_off;
      end else if (per_cnt == '1 && state != pcc_pkg::lk_off) begin
         next_state = pcc_pkg::lk_acq;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= pcc_pkg::lk_off;
         lock <= 1'b0;
         good_cnt <= 8'h00;
      end else begin
         state <= next_state;
         lock <= (next_state == pcc_pkg::lk_locked); // [R13]
         if (state != pcc_pkg::lk_acq) begin
            good_cnt <= 8'h00;
         end else if (ref_tick) begin
            good_cnt <= good ? good_cnt + 8'h01 : 8'h00;
         end
      end
   end

   // output routing
   always_comb begin
      unique case (pr)
         pcc_pkg::PR_BYP: psrc = primary_ref_pad; // [R8]
         pcc_pkg::PR_GMUX: psrc = prim_ref;
         pcc_pkg::PR_DLY: psrc = vdl_out;
         pcc_pkg::PR_RSV: psrc = 1'b0;
         3'h4, 3'h5, 3'h6, 3'h7: psrc = phase_lvl(vco_ph, pr[1:0]); // [R9]
      endcase
      unique case (sr)
         pcc_pkg::SR_BYP: ssrc = secondary_ref_pad; // [R10]
         pcc_pkg::SR_GMUX: ssrc = secondary_ref_in; // [R16]
         pcc_pkg::SR_DLY: ssrc = vdl_out;
         pcc_pkg::SR_PH0: ssrc = phase_lvl(vco_ph, 2'h0);
      endcase
   end

   pcc_out_path #(.DL_LEN(DL_LEN)) u_primary ( // [R20]
      .clk     (aclk),
      .rstn    (aresetn),
      .src     (psrc),
      .div_sel (eff[pcc_pkg::PD_LSB +: pcc_pkg::DIV_W]),
      .dly_sel (eff[pcc_pkg::PDL_LSB +: pcc_pkg::DLS_W]),
      .clk_out (primary_clk_out)
   );

   pcc_out_path #(.DL_LEN(DL_LEN)) u_secondary ( // [R20]
      .clk     (aclk),
      .rstn    (aresetn),
      .src     (ssrc),
      .div_sel (eff[pcc_pkg::SD_LSB +: pcc_pkg::DIV_W]),
      .dly_sel (eff[pcc_pkg::SDL_LSB +: pcc_pkg::DLS_W]),
      .clk_out (secondary_clk_out)
   );

   // AXI4-Lite write side
   assign wr_go = aw_hold && w_hold && !bvalid;
   assign wr_hit = aw_q == pcc_pkg::ADDR_CFG || aw_q == pcc_pkg::ADDR_CTRL ||
                   aw_q == pcc_pkg::ADDR_STAT || aw_q == pcc_pkg::ADDR_DYN;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_hold <= 1'b0;
         aw_q <= 8'h00;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_hold <= 1'b1;
         aw_q <= awaddr;
      end else if (wr_go) begin
         aw_hold <= 1'b0;
      end else if (!aw_hold && !bvalid) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_hold <= 1'b0;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_hold <= 1'b1;
         wd_q <= wdata;
         ws_q <= wstrb;
      end else if (wr_go) begin
         w_hold <= 1'b0;
      end else if (!w_hold && !bvalid) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= pcc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg <= pcc_pkg::CFG_RST;
         ctrl_reg <= pcc_pkg::CTRL_RST;
      end else if (wr_go && aw_q == pcc_pkg::ADDR_CFG) begin
         cfg_reg <= merge(cfg_reg, wd_q, ws_q) & pcc_pkg::CFG_MASK;
      end else if (wr_go && aw_q == pcc_pkg::ADDR_CTRL) begin
         ctrl_reg <= merge(ctrl_reg, wd_q, ws_q) & pcc_pkg::CTRL_MASK; // [R14]
      end
   end

   // AXI4-Lite read side
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (araddr)
         pcc_pkg::ADDR_CFG: rd_word = cfg_reg;
         pcc_pkg::ADDR_CTRL: rd_word = ctrl_reg;
         pcc_pkg::ADDR_STAT: begin
            rd_word[pcc_pkg::ST_LOCK] = lock;
            rd_word[pcc_pkg::ST_CORE] = core_on;
            rd_word[pcc_pkg::ST_SOUT] = cfg_serial_out;
            rd_word[pcc_pkg::ST_DYN] = mode;
         end
         pcc_pkg::ADDR_DYN: rd_word = {1'b0, dyn_cfg};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= pcc_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= rd_hit ? pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence shift_s;
      mode && cfg_shift_en && cfg_serial_clk && !sclk_q;
   endsequence

   in_div_wrap_a: // [R1]
      assert property (core_on && prim_ref && !pref_q && in_cnt == n_sel
                       |=> ref_tick && in_cnt == 5'h00)
      else $error("input divider does not wrap at code plus one");
   fb_div_wrap_a: // [R2]
      assert property (core_on && fb_ev && fb_cnt == m_sel |=> fb_cnt == 6'h00)
      else $error("feedback divider does not wrap at code plus one");
   lock_off_a: // [R13]
      assert property (!core_on |=> !lock && state == pcc_pkg::lk_off)
      else $error("lock shown while the core is off");
   lock_rise_a: // [R13]
      assert property ($rose(lock) |-> $past(ref_tick) && $past(state) == pcc_pkg::lk_acq)
      else $error("lock rose without a checked reference period");
   core_idle_a: // [R22]
      assert property (!core_on |=> vco_ph == 2'h0 && acc == '0)
      else $error("oscillator runs while both outputs bypass");
   serial_out_a: // [R15]
      assert property (shift_s |=> cfg_serial_out == $past(shreg[W-2]))
      else $error("serial output does not show the shift register end");
   static_ign_a: // [R19]
      assert property (!mode |=> $stable(shreg) && $stable(dyn_cfg))
      else $error("serial inputs acted in static mode");
   mode_pick_a: // [R14]
      assert property (!mode |-> eff == {1'b0, cfg_reg[W-2:0]})
      else $error("static mode does not use the static word");
   dyn_load_a: // [R19]
      assert property (mode && cfg_update_strobe && !upd_q |=> dyn_cfg == $past(shreg))
      else $error("update strobe did not load the dynamic word");
endmodule

// *** sim/pcc_ref_model.sv ***
// pcc_ref_model: reference clock sources of the user logic around pcc_top
// assumes references free-running and synchronous to aclk
`timescale 1ns/100ps
module pcc_ref_model #(
   parameter int P_HALF = 4,
   parameter int Q_HALF = 5,
   parameter int S_HALF = 6,
   parameter int T_HALF = 3
) (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // reference clocks
   output logic      primary_ref_pad,
   output logic      primary_ref_int,
   output logic      secondary_ref_pad,
   output logic      secondary_ref_int
);
   int n;

   // four distinct periods so each source can be told apart at the outputs
   always_ff @(posedge aclk) begin
      n <= aresetn ? n + 1 : 0;
      primary_ref_pad   <= aresetn && ((n / P_HALF) % 2 == 1);
      primary_ref_int   <= aresetn && ((n / Q_HALF) % 2 == 1);
      secondary_ref_pad <= aresetn && ((n / S_HALF) % 2 == 1);
      secondary_ref_int <= aresetn && ((n / T_HALF) % 2 == 1);
   end
endmodule

// *** sim/pcc_top_bench.sv ***
// pcc_top_bench: register, clock path, lock and serial tests of pcc_top
// assumes pcc_ref_model drives the references, AXI4-Lite master tasks here
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module pcc_top_bench;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, lock;
   logic        primary_ref_pad, primary_ref_int, secondary_ref_pad, secondary_ref_int;
   logic        cfg_serial_clk, cfg_shift_en, cfg_serial_in, cfg_update_strobe;
   logic        cfg_serial_out, primary_clk_out, secondary_clk_out;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   logic [30:0] pat;
   int          error_cnt, n_checks, p;
   wire         ext_feedback_in = primary_clk_out;

   initial aclk = 1'b0;
   always #4 aclk = ~aclk;

   pcc_ref_model i_pcc_ref_model (.aclk, .aresetn, .primary_ref_pad, .primary_ref_int,
      .secondary_ref_pad, .secondary_ref_int);
   pcc_top #(.PER_W(10), .LOCK_PERIODS(2)) i_pcc_top (.aclk, .aresetn, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .primary_ref_pad,
      .primary_ref_int, .secondary_ref_pad, .secondary_ref_int, .ext_feedback_in,
      .cfg_serial_clk, .cfg_shift_en, .cfg_serial_in, .cfg_update_strobe, .cfg_serial_out,
      .primary_clk_out, .secondary_clk_out, .lock);

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
         @(negedge aclk);
         ta |= awready;
         tw |= wready;
         @(posedge aclk);
         awvalid <= !ta;
         wvalid  <= !tw;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      rready <= 1'b0;
      `CHK(nm, e, rd)
      `CHK(nm, er, rs)
   endtask

   // cycles between the 2nd and 3rd rising edge, 0 if none; settings held meanwhile
   task automatic per(input logic s, output int q);
      int   n, k, t0;
      logic pv, cv;
      n  = 0;
      k  = 0;
      t0 = 0;
      q  = 0;
      pv = 1'b1;
      repeat (300) begin
         @(negedge aclk);
         n++;
         cv = s ? secondary_clk_out : primary_clk_out;
         if (cv === 1'b1 && pv === 1'b0) begin
            k++;
            if (k == 2) t0 = n;
            if (k == 3) q = n - t0;
         end
         pv = cv;
      end
   endtask

   task automatic tc(input logic [31:0] c, input logic [31:0] f, input int ep, input int es);
      wr(8'h04, c, rs);
      wr(8'h00, f, rs);
      repeat (60) @(posedge aclk);
      per(1'b0, p);
      `CHK("prim_period", ep, p)
      per(1'b1, p);
      `CHK("sec_period", es, p)
   endtask

   task automatic sh(input logic b);
      @(posedge aclk);
      cfg_serial_in  <= b;
      cfg_serial_clk <= 1'b1;
      @(posedge aclk);
      cfg_serial_clk <= 1'b0;
   endtask

   task automatic stb;
      @(posedge aclk);
      cfg_update_strobe <= 1'b1;
      @(posedge aclk);
      cfg_update_strobe <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   task final_report;
      if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      final_report;
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {cfg_serial_clk, cfg_serial_in, cfg_update_strobe} = '0;
      {awaddr, araddr, wdata} = '0;
      cfg_shift_en = 1'b1;
      wstrb = 4'hF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("ctrl_rst", 8'h04, 32'h0000_0000, pcc_pkg::RESP_OKAY);
      rchk("unmapped", 8'h10, 32'h0000_0000, pcc_pkg::RESP_SLVERR);
      wr(8'h00, 32'hFFFF_FFFF, rs);
      `CHK("wr_resp", pcc_pkg::RESP_OKAY, rs)
      rchk("cfg_rw", 8'h00, pcc_pkg::CFG_MASK, pcc_pkg::RESP_OKAY);
      wstrb <= 4'h1;
      wr(8'h00, 32'h0000_0000, rs);
      wstrb <= 4'hF;
      rchk("cfg_lane", 8'h00, 32'h7FFF_FF00, pcc_pkg::RESP_OKAY);
      wr(8'h10, 32'h0000_0001, rs);
      `CHK("wr_unmapped", pcc_pkg::RESP_SLVERR, rs)
      tc(0, 32'h0000_0000, 8, 12);
      tc(0, 32'h0000_2800, 16, 24);
      tc(0, 32'h0000_5000, 24, 36);
      tc(0, 32'h0000_7800, 32, 48);
      tc(6, 32'h0004_8000, 10, 6);
      tc(0, 32'h0001_8000, 0, 12);
      for (int k = 4; k < 8; k++) tc(0, 32'h002C_0000 | (32'(k) << 15), 8, 8);
      tc(0, 32'h002E_0020, 4, 4);
      tc(0, 32'h002E_0021, 8, 8);
      `CHK("lock_on", 1'b1, lock)
      tc(0, 32'h001E_0021, 8, 8);
      tc(0, 32'h003E_0021, 8, 8);
      wr(8'h00, 32'h000E_0021, rs);
      repeat (80) @(posedge aclk);
      `CHK("lock_gnd", 1'b0, lock)
      wr(8'h00, 32'h0000_0000, rs);
      repeat (20) @(posedge aclk);
      rchk("stat_off", 8'h08, 32'h0000_0000, pcc_pkg::RESP_OKAY);
      wr(8'h04, 32'h0000_0001, rs);
      pat = 31'h4A5C_3B19;
      for (int i = 30; i >= 0; i--) sh(pat[i]);
      @(negedge aclk);
      `CHK("serial_out", pat[30], cfg_serial_out)
      stb;
      rchk("dyn_load", 8'h0C, {1'b0, pat}, pcc_pkg::RESP_OKAY);
      wr(8'h04, 32'h0000_0000, rs);
      for (int i = 30; i >= 0; i--) sh(~pat[i]);
      stb;
      rchk("dyn_static", 8'h0C, {1'b0, pat}, pcc_pkg::RESP_OKAY);
      final_report;
   end
endmodule
